/* File: hw/scp_spi_slave.sv */
// Serial configuration slave port with its outbound command queue
// Notes on behaviour
// RULE1: Every byte shifts most significant bit first, both directions.
// RULE2: Host opens each transaction with rw bit, burst bit, six address bits.
// RULE3: Host keeps chip_select_n low for the whole transfer.
// RULE4: Chip select rising mid byte aborts; no partial byte is applied.
// RULE5: Host waits for serial_out low before clocking the header.
// RULE6: Serial_out goes low at once, unless powered down or oscillator off.
// RULE7: A status byte shifts out while header, data or command shifts in.
// RULE8: Status bit 7 stays high until the oscillator is stable.
// RULE9: Status bits 6:4 carry the radio mode code.
// RULE10: Mode code 100 during tuning, 101 during lock wait.
// RULE11: Codes 110 and 111 hold until the matching flush command.
// RULE12: Transitional states may report idle instead of tuning codes.
// RULE13: Low nibble is rx bytes readable for reads, tx free for writes.
// RULE14: The four bit count saturates at 15.
// RULE15: Configuration registers 0x00 to 0x2E are writable and readable.
// RULE16: Header rw bit selects write from serial_in or read out.
// RULE17: Writes return a status byte for header and every data byte.
// RULE18: Reads return status only for the header, then register contents.
// RULE19: Burst bit loads the address into an internal counter.
// RULE20: Host changes frequency settings only while the radio is idle.
// RULE21: Burst address advances once per byte until chip select rises; the code advances it only from 0x2E or lower, so it holds at 0x2F.
// RULE22: In 0x30 to 0x3D burst picks status read, else a strobe.
// RULE23: Sample serial_in on rising clock, update serial_out after falling.
`timescale 1ns/100ps
`include "scp_params.svh"

module scp_fifo #(
    parameter int WIDTH = `SCP_FIFO_W,
    parameter int DEPTH = `SCP_FIFO_D,
    parameter int AW = `SCP_FIFO_AW
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic push;
    logic pop;

    assign o_in_ready = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
    assign o_out_valid = wptr != rptr;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rptr[AW-1:0]];

    always_ff @(posedge i_clk_sys) begin
        if (i_clk_en && push) begin
            mem[wptr[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wptr <= '0;
            rptr <= '0;
        end else if (i_clk_en) begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule // scp_fifo

module scp_spi_slave (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    input wire logic i_chip_select_n,
    output logic o_serial_out,
    output logic o_serial_out_oe,
    input wire logic i_osc_running,
    input wire logic i_deep_powerdown,
    input wire logic i_osc_off,
    input wire logic [2:0] i_radio_mode,
    input wire logic i_mode_transit,
    input wire logic [6:0] i_rx_count,
    input wire logic [6:0] i_tx_free,
    input wire logic [5:0] i_cfg_raddr,
    output logic [7:0] o_cfg_rdata,
    output logic [5:0] o_ext_addr,
    input wire logic [7:0] i_ext_rdata,
    output logic o_cmd_valid,
    input wire logic i_cmd_ready,
    output scp_pkg::scp_cmd_t o_cmd
);
    // ============================================================
    // Pin synchronisers
    logic [1:0] sclk_sy;
    logic [1:0] sdi_sy;
    logic [1:0] csn_sy;
    logic [1:0] osc_sy;
    logic [1:0] pd_sy;
    logic sclk_d;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sclk_sy <= 2'h0;
            sdi_sy <= 2'h0;
            csn_sy <= 2'h3;
            osc_sy <= 2'h0;
            pd_sy <= 2'h0;
            sclk_d <= 1'b0;
        end else if (i_clk_en) begin
            sclk_sy <= {sclk_sy[0], i_sclk};
            sdi_sy <= {sdi_sy[0], i_serial_in};
            csn_sy <= {csn_sy[0], i_chip_select_n};
            osc_sy <= {osc_sy[0], i_osc_running};
            pd_sy <= {pd_sy[0], i_deep_powerdown | i_osc_off};
            sclk_d <= sclk_sy[1];
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_act;
    logic sdi;
    assign sck_rise = sclk_sy[1] && !sclk_d;
    assign sck_fall = !sclk_sy[1] && sclk_d;
    assign cs_act = !csn_sy[1];
    assign sdi = sdi_sy[1];

    // ============================================================
    // Status byte
    scp_pkg::scp_status_t status;
    scp_pkg::scp_state_t state;
    logic rw;
    logic burst;
    logic [5:0] addr;
    logic [6:0] cnt_raw;

    assign cnt_raw = rw ? i_rx_count : i_tx_free; // [RULE13]
    always_comb begin
        status.osc_not_ready = !osc_sy[1]; // [RULE8]
        // Radio keeps overrun/underrun codes until flushed [RULE11]
        // Transit flag masks tuning codes as idle [RULE12]
        status.mode = i_mode_transit ? 3'h0 : i_radio_mode; // [RULE9] [RULE10]
        status.count = (cnt_raw >= `SCP_CNT_SAT) ? `SCP_CNT_MAX
                                                : cnt_raw[3:0]; // [RULE14]
    end

    // ============================================================
    // Byte framing
    logic [2:0] bitcnt;
    logic [6:0] rx;
    logic first_wait;
    logic byte_end;
    logic [7:0] rx_byte;
    logic [7:0] rd_byte;
    logic ld_rd;
    logic is_cfg;
    logic is_sts;
    logic hdr_data;

    assign byte_end = cs_act && sck_rise && bitcnt == `SCP_BIT_LAST;
    assign rx_byte = {rx, sdi}; // [RULE1]
    assign is_cfg = rx_byte[5:0] <= `SCP_CFG_LAST;
    assign is_sts = rx_byte[5:0] >= `SCP_STS_FIRST && rx_byte[5:0] <= `SCP_STS_LAST;
    // Strobes are header-only; anything else carries data [RULE22]
    assign hdr_data = !is_sts || rx_byte[6];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            bitcnt <= 3'h0;
            rx <= 7'h00;
        end else if (i_clk_en) begin
            if (!cs_act) begin
                bitcnt <= 3'h0; // [RULE4]
            end else if (sck_rise) begin
                bitcnt <= bitcnt + 3'h1;
                rx <= rx_byte[6:0]; // [RULE23]
            end
        end
    end

    // ============================================================
    // Transaction state
    logic cfg_we;
    logic cmd_push;
    logic cmd_ready;
    scp_pkg::scp_cmd_t cmd;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= scp_pkg::SCP_IDLE;
            rw <= 1'b0;
            burst <= 1'b0;
            addr <= 6'h00;
        end else if (i_clk_en) begin
            if (!cs_act) begin
                state <= scp_pkg::SCP_IDLE; // [RULE4]
            end else begin
                case (state)
                    scp_pkg::SCP_IDLE: begin
                        state <= scp_pkg::SCP_HDR;
                    end
                    scp_pkg::SCP_HDR: begin
                        if (sck_rise && bitcnt == 3'h0) begin
                            rw <= sdi; // [RULE16]
                        end
                        if (byte_end) begin
                            burst <= rx_byte[6];
                            addr <= rx_byte[5:0]; // [RULE19]
                            if (hdr_data) begin
                                state <= scp_pkg::SCP_DATA;
                            end
                        end
                    end
                    scp_pkg::SCP_DATA: begin
                        if (byte_end) begin
                            if (!burst || addr >= `SCP_STS_FIRST && addr <= `SCP_STS_LAST) begin
                                state <= scp_pkg::SCP_HDR; // [RULE22]
                            end else if (addr <= `SCP_CFG_LAST) begin
                                addr <= addr + 6'h01; // [RULE21]
                            end
                        end
                    end
                    default: begin
                        state <= scp_pkg::SCP_IDLE;
                    end
                endcase
            end
        end
    end

    // Write lands only on a complete byte [RULE4]
    assign cfg_we = byte_end && state == scp_pkg::SCP_DATA && !rw
                    && addr <= `SCP_CFG_LAST; // [RULE15]
    assign cmd_push = byte_end && ((state == scp_pkg::SCP_HDR && !hdr_data)
                    || (state == scp_pkg::SCP_DATA && !rw && addr > `SCP_CFG_LAST));
    // A full queue drops the byte; the radio must drain faster than the link
    always_comb begin
        cmd.rw = state == scp_pkg::SCP_HDR ? rx_byte[7] : rw;
        cmd.burst = state == scp_pkg::SCP_HDR ? rx_byte[6] : burst;
        cmd.addr = state == scp_pkg::SCP_HDR ? rx_byte[5:0] : addr;
        cmd.data = state == scp_pkg::SCP_HDR ? `SCP_RST_BYTE : rx_byte;
    end

    scp_fifo #(
        .WIDTH(`SCP_FIFO_W),
        .DEPTH(`SCP_FIFO_D),
        .AW(`SCP_FIFO_AW)
    ) u_cmd_q (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_in_valid(cmd_push),
        .o_in_ready(cmd_ready),
        .i_in_data(cmd),
        .o_out_valid(o_cmd_valid),
        .i_out_ready(i_cmd_ready),
        .o_out_data(o_cmd)
    );

    // ============================================================
    // Configuration registers
    logic [7:0] cfg [0:`SCP_CFG_N-1];
    genvar g;
    generate
        for (g = 0; g < `SCP_CFG_N; g++) begin : g_cfg
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    cfg[g] <= `SCP_RST_BYTE;
                end else if (i_clk_en && cfg_we && addr == 6'(g)) begin
                    cfg[g] <= rx_byte; // [RULE15]
                end
            end
        end
    endgenerate

    assign o_ext_addr = addr;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_cfg_rdata <= `SCP_RST_BYTE;
            rd_byte <= `SCP_RST_BYTE;
            ld_rd <= 1'b0;
        end else if (i_clk_en) begin
            o_cfg_rdata <= i_cfg_raddr <= `SCP_CFG_LAST ? cfg[i_cfg_raddr]
                                                       : `SCP_RST_BYTE;
            // Reload one cycle after the address settles
            ld_rd <= byte_end;
            if (ld_rd) begin
                rd_byte <= addr <= `SCP_CFG_LAST ? cfg[addr] : i_ext_rdata; // [RULE18]
            end
        end
    end

    // ============================================================
    // Serial output
    logic [7:0] out_byte;
    logic sdo_first;
    assign out_byte = (state == scp_pkg::SCP_DATA && rw) ? rd_byte : status; // [RULE7] [RULE17]
    assign sdo_first = pd_sy[1] ? !osc_sy[1] : 1'b0; // [RULE6]
    assign o_serial_out_oe = cs_act;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_serial_out <= 1'b0;
            first_wait <= 1'b0;
        end else if (i_clk_en) begin
            if (!cs_act) begin
                o_serial_out <= 1'b0;
                first_wait <= 1'b1;
            end else if (first_wait) begin
                o_serial_out <= sdo_first; // [RULE6]
                first_wait <= !sck_rise;
            end else if (sck_fall) begin
                o_serial_out <= out_byte[`SCP_BIT_LAST - bitcnt]; // [RULE1] [RULE23]
            end
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n || !i_clk_en);

    sequence s_byte_end;
        cs_act && sck_rise && bitcnt == `SCP_BIT_LAST;
    endsequence
    sequence s_burst_cfg_byte;
        s_byte_end ##0 state == scp_pkg::SCP_DATA && burst && addr < `SCP_CFG_LAST;
    endsequence

    a_write_whole_byte: assert property (cfg_we |-> s_byte_end) // [RULE4]
        else $error("config write outside a byte boundary");
    a_abort_idle: assert property (!cs_act |=> state == scp_pkg::SCP_IDLE) // [RULE4]
        else $error("chip select release did not abort");
    a_first_low_awake: assert property (cs_act && first_wait && !pd_sy[1] |=> !o_serial_out) // [RULE6]
        else $error("serial_out not low at select while awake");
    a_msb_first_hdr: assert property (s_byte_end ##0 state == scp_pkg::SCP_HDR
        |=> addr == $past(rx_byte[5:0])) // [RULE1]
        else $error("header address not taken msb first");
    a_burst_step: assert property (s_burst_cfg_byte |=> addr == $past(addr) + 6'h01) // [RULE21]
        else $error("burst address did not advance");
    a_count_sat: assert property (cnt_raw > `SCP_CNT_SAT |-> status.count == `SCP_CNT_MAX) // [RULE14]
        else $error("fifo count did not saturate");
    a_count_dir: assert property (!rw && i_tx_free < `SCP_CNT_SAT
        |-> status.count == i_tx_free[3:0]) // [RULE13]
        else $error("write count not tx free bytes");
    a_mode_idle: assert property (i_mode_transit |-> status.mode == 3'h0) // [RULE12]
        else $error("transitional state not idle");
    a_strobe_hdr: assert property (s_byte_end ##0 state == scp_pkg::SCP_HDR && is_sts && !rx_byte[6]
        |=> state == scp_pkg::SCP_HDR) // [RULE22]
        else $error("strobe expected data bytes");
    a_read_data: assert property (cs_act && !first_wait && sck_fall && state == scp_pkg::SCP_DATA && rw
        |=> o_serial_out == $past(rd_byte[`SCP_BIT_LAST - bitcnt])) // [RULE18]
        else $error("read data not shifted out");
endmodule // scp_spi_slave

/* File: pkg/scp_params.svh */
// Constants of the serial configuration slave port
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
// ============================================================
// Address map
`define SCP_CFG_LAST 6'h2E
`define SCP_CFG_N 47
`define SCP_STS_FIRST 6'h30
`define SCP_STS_LAST 6'h3D
// ============================================================
// Byte framing and status
`define SCP_BIT_LAST 3'h7
`define SCP_CNT_MAX 4'hF
`define SCP_CNT_SAT 7'h0F
`define SCP_RST_BYTE 8'h00
// ============================================================
// Command queue
`define SCP_FIFO_W 16
`define SCP_FIFO_D 16
`define SCP_FIFO_AW 4
`endif

/* File: pkg/scp_pkg.sv */
// Types of the serial configuration slave port
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_IDLE,
        SCP_HDR,
        SCP_DATA
    } scp_state_t;
    typedef struct packed {
        logic rw;
        logic burst;
        logic [5:0] addr;
        logic [7:0] data;
    } scp_cmd_t;
    typedef struct packed {
        logic osc_not_ready;
        logic [2:0] mode;
        logic [3:0] count;
    } scp_status_t;
endpackage

/* File: sim/scp_host_model.sv */
// Host-side serial bus master model
`timescale 1ns/100ps
module scp_host_model (
    output logic o_sclk,
    output logic o_sdi,
    output logic o_csn,
    input wire logic i_sdo
);
    // ============================================================
    // Idle link: clock stands low, select high
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_sdi = 1'b0;
    end
    // ============================================================
    // Select, then bounded wait for serial_out low
    task automatic sel(output bit ok);
        o_csn = 1'b0;
        ok = 1'b0;
        #50;
        for (int k = 0; k < 40 && !ok; k++) begin
            #10 ok = (i_sdo === 1'b0);
        end
    endtask
    // Fewer than 8 bits leaves a partial byte
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            o_sdi = tx[i];
            #62.5 o_sclk = 1'b1;
            rx[i] = i_sdo;
            #62.5 o_sclk = 1'b0;
        end
        // Released data must not look held
        o_sdi = ~o_sdi;
    endtask
    task automatic desel();
        #40 o_csn = 1'b1;
        #300;
    endtask
endmodule // scp_host_model

/* File: sim/tb.sv */
// Self-checking bench of the serial configuration slave port
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_run = 1'b1;
    logic dpd = 1'b0;
    logic osc_off = 1'b0;
    logic transit = 1'b0;
    logic cmd_ready = 1'b0;
    // Config is written while the radio reports idle
    logic [2:0] mode = 3'h0;
    logic [6:0] rx_cnt = 7'h14;
    logic [6:0] tx_free = 7'h03;
    logic [5:0] cfg_raddr = 6'h00;
    logic [7:0] ext_rdata = 8'h5C;
    logic [7:0] rx, cfg_rdata;
    logic [5:0] ext_addr;
    logic sclk, sdi, chip_select_n, sdo, oe, cmd_valid;
    logic sdo_line;
    scp_pkg::scp_cmd_t cmd;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    bit ok;

    scp_spi_slave scp_spi_slave_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
        .i_sclk(sclk), .i_serial_in(sdi), .i_chip_select_n(chip_select_n), .o_serial_out(sdo),
        .o_serial_out_oe(oe), .i_osc_running(osc_run), .i_deep_powerdown(dpd),
        .i_osc_off(osc_off), .i_radio_mode(mode), .i_mode_transit(transit),
        .i_rx_count(rx_cnt), .i_tx_free(tx_free), .i_cfg_raddr(cfg_raddr),
        .o_cfg_rdata(cfg_rdata), .o_ext_addr(ext_addr), .i_ext_rdata(ext_rdata),
        .o_cmd_valid(cmd_valid), .i_cmd_ready(cmd_ready), .o_cmd(cmd));
    // Released line shows the inverse of serial_out, which deselect clears, so it reads high
    assign sdo_line = oe ? sdo : ~sdo;
    scp_host_model scp_host_model_i (.o_sclk(sclk), .o_sdi(sdi), .o_csn(chip_select_n), .i_sdo(sdo_line));

    // ============================================================
    // Clock and hang guard
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ============================================================
    // Compare and access tasks
    task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk16(input string w, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    function automatic logic [7:0] sts(input logic rw);
        logic [6:0] c;
        c = rw ? rx_cnt : tx_free;
        return {~osc_run, transit ? 3'h0 : mode, (c > 7'h0F) ? 4'hF : c[3:0]};
    endfunction
    task automatic xc(input string w, input logic [7:0] t, input logic [7:0] e);
        scp_host_model_i.xfer(t, 8, rx);
        chk8(w, e, rx);
    endtask
    task automatic sel();
        scp_host_model_i.sel(ok);
        chk8("awake", 8'h01, {7'h00, ok});
        chk8("oe", 8'h01, {7'h00, oe});
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        sel();
        xc("wr hdr status", {2'b00, a}, sts(1'b0));
        xc("wr data status", d, sts(1'b0));
        scp_host_model_i.desel();
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        sel();
        xc("rd hdr status", {2'b10, a}, sts(1'b1));
        xc("rd data", 8'h00, e);
        scp_host_model_i.desel();
    endtask
    task automatic pr(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk) cfg_raddr <= a;
        repeat (3) @(posedge clk);
        chk8("cfg port", e, cfg_rdata);
    endtask
    task automatic pop(input logic [15:0] e);
        for (int k = 0; k < 20 && cmd_valid !== 1'b1; k++) @(posedge clk);
        chk16("cmd head", e, cmd);
        @(posedge clk) cmd_ready <= 1'b1;
        @(posedge clk) cmd_ready <= 1'b0;
        // Far side stalls two cycles between pops
        repeat (2) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ============================================================
    // Test sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wr(6'h05, 8'hA5);
        rd(6'h05, 8'hA5);
        rd(6'h06, 8'h00);
        pr(6'h05, 8'hA5);
        pr(6'h2F, 8'h00);
        $display("test single done");
        sel();
        xc("burst hdr", 8'h6D, sts(1'b0));
        xc("burst d0", 8'h11, sts(1'b0));
        xc("burst d1", 8'h22, sts(1'b0));
        xc("burst d2", 8'h33, sts(1'b0));
        scp_host_model_i.desel();
        rd(6'h2D, 8'h11);
        rd(6'h2E, 8'h22);
        sel();
        xc("brd hdr", 8'hED, sts(1'b1));
        xc("brd d0", 8'h00, 8'h11);
        xc("brd d1", 8'h00, 8'h22);
        scp_host_model_i.desel();
        $display("test burst done");
        sel();
        xc("abort hdr", 8'h07, sts(1'b0));
        scp_host_model_i.xfer(8'h5A, 4, rx);
        scp_host_model_i.desel();
        sel();
        scp_host_model_i.xfer(8'h05, 5, rx);
        scp_host_model_i.desel();
        rd(6'h07, 8'h00);
        rd(6'h05, 8'hA5);
        $display("test abort done");
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            mode <= m[2:0];
            rx_cnt <= 7'(m * 3);
            transit <= (m == 4);
            rd(6'h00, 8'h00);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            dpd <= (k == 0);
            osc_off <= (k == 1);
            osc_run <= 1'b0;
            scp_host_model_i.sel(ok);
            chk8("asleep", 8'h00, {7'h00, ok});
            @(posedge clk) osc_run <= 1'b1;
            sel();
            xc("wake status", 8'h80, sts(1'b1));
            scp_host_model_i.desel();
        end
        @(posedge clk) osc_off <= 1'b0;
        $display("test status done");
        sel();
        xc("strobe", 8'h36, sts(1'b0));
        xc("sreg hdr", 8'hF5, sts(1'b1));
        xc("sreg data", 8'h00, 8'h5C);
        chk8("ext addr", 8'h35, {2'b00, ext_addr});
        scp_host_model_i.desel();
        pop(16'h6F33);
        pop(16'h3600);
        sel();
        xc("q hdr", 8'h7F, sts(1'b0));
        for (int i = 0; i < 17; i++) xc("q status", 8'hC0 + 8'(i), sts(1'b0));
        scp_host_model_i.desel();
        for (int j = 0; j < 16; j++) pop({8'h7F, 8'hC0 + 8'(j)});
        chk8("q empty", 8'h00, {7'h00, cmd_valid});
        $display("test queue done");
        tally_and_finish();
    end
endmodule // tb
